// File: rtl/rcs_ref_switch.sv
// Reference clock selection, loss detection and reference configuration
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rcs_ref_switch
	import rcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic crystal_or_ref_input,
	input wire logic second_ref_input,
	input wire logic input_clock_select_pin,
	input wire logic [RCS_AW-1:0] reg_addr,
	input wire logic [RCS_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [RCS_DW-1:0] reg_rdata,
	output logic ref_out,
	output logic using_secondary,
	output logic primary_lost,
	output logic [RCS_NPLL-1:0] pll_power_down,
	output logic pll3_div_invalid,
	output logic [RCS_CAPW-1:0] load_cap_steps,
	output logic [1:0] crystal_drive_strength,
	output logic [RCS_MW-1:0] fb_multiplier
);
	// Bits: select pin, second input, crystal/ref input, from the top
	localparam int NSYNC = 3;

	// Synchroniser state: stage one, stage two, previous of stage two
	logic [NSYNC-1:0] sync1, sync2, sync_prev;
	logic [NSYNC-1:0] next_sync1, next_sync2, next_sync_prev;

	// Configuration registers
	logic primary_source_select;
	logic [1:0] switchover_mode;
	logic [RCS_DIVW-1:0] prediv [RCS_NPLL];
	logic [RCS_TRIMW-1:0] crystal_load_trim;
	logic [RCS_FBW-1:0] feedback_count;
	logic [RCS_FRW-1:0] feedback_fraction_add;
	logic next_primary_source_select;
	logic [1:0] next_switchover_mode;
	logic [RCS_DIVW-1:0] next_prediv [RCS_NPLL];
	logic [RCS_TRIMW-1:0] next_crystal_load_trim;
	logic [1:0] next_crystal_drive_strength;
	logic [RCS_FBW-1:0] next_feedback_count;
	logic [RCS_FRW-1:0] next_feedback_fraction_add;

	// Selection state
	logic [RCS_CNTW-1:0] sec_periods, next_sec_periods;
	logic next_primary_lost, next_using_secondary, next_ref_out;

	// Derived outputs and read data
	logic [RCS_NPLL-1:0] next_pll_power_down;
	logic next_pll3_div_invalid;
	logic [RCS_CAPW-1:0] next_load_cap_steps;
	logic [RCS_MW-1:0] next_fb_multiplier;
	logic [RCS_DW-1:0] next_reg_rdata;

	// Source views in primary/secondary terms
	logic prim_lvl, sec_lvl, prim_edge, sec_rise, pin_lvl, auto_mode, want_secondary;
	logic cur_lvl, tgt_lvl;

	// Two-flop synchronisers on all pins
	// Pins are asynchronous to sys_clk; only the second stage reads the first
	always_comb
	begin
		next_sync1 = {input_clock_select_pin, second_ref_input, crystal_or_ref_input};
		next_sync2 = sync1;
		next_sync_prev = sync2;
	end

	// Synchroniser flops reset to the pins' idle low level
	// A pin high at release gives one false edge, harmless beside a running primary
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync_prev <= '0;
		end
		else
		begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync_prev <= next_sync_prev;
		end
	end

	// Map physical inputs onto primary and secondary roles
	// Edges compare the second stage with its previous value
	always_comb
	begin
		prim_lvl = primary_source_select ? sync2[1] : sync2[0];
		sec_lvl = primary_source_select ? sync2[0] : sync2[1];
		prim_edge = primary_source_select ? (sync2[1] ^ sync_prev[1])
			: (sync2[0] ^ sync_prev[0]);
		sec_rise = primary_source_select ? (sync2[0] & ~sync_prev[0])
			: (sync2[1] & ~sync_prev[1]);
		pin_lvl = sync2[2];
		auto_mode = switchover_mode[1];
	end

	// Register writes
	// Unmapped offsets match no compare, so such writes are dropped
	// Control holds the primary choice and the two mode bits
	always_comb
	begin
		next_primary_source_select = primary_source_select;
		next_switchover_mode = switchover_mode;
		next_prediv = prediv;
		next_crystal_load_trim = crystal_load_trim;
		next_crystal_drive_strength = crystal_drive_strength;
		next_feedback_count = feedback_count;
		next_feedback_fraction_add = feedback_fraction_add;
		if (reg_wr)
		begin
			if (reg_addr == RCS_OFS_CTRL)
			begin
				next_primary_source_select = reg_wdata[RCS_CTRL_PRIM_BIT];
				next_switchover_mode = reg_wdata[RCS_CTRL_MODE_HI:RCS_CTRL_MODE_LO];
			end
			for (int i = 0; i < RCS_NPLL; i++)
			begin
				if (reg_addr == RCS_OFS_PREDIV0 + RCS_AW'(i))
					next_prediv[i] = reg_wdata[RCS_DIVW-1:0];
			end
			if (reg_addr == RCS_OFS_TRIM)
				next_crystal_load_trim = reg_wdata[RCS_TRIMW-1:0];
			if (reg_addr == RCS_OFS_DRIVE)
				next_crystal_drive_strength = reg_wdata[1:0];
			if (reg_addr == RCS_OFS_FEEDBACK)
			begin
				next_feedback_count = reg_wdata[RCS_FBW-1:0];
				next_feedback_fraction_add = reg_wdata[RCS_FB_ADD_LO+RCS_FRW-1:RCS_FB_ADD_LO];
			end
		end
	end

	// Configuration registers; reset leaves every PLL running
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			primary_source_select <= 1'b0;
			switchover_mode <= 2'h0;
			for (int i = 0; i < RCS_NPLL; i++)
				prediv[i] <= (i == RCS_LAST_PLL) ? RCS_PREDIV3_RST : RCS_PREDIV_RST;
			crystal_load_trim <= RCS_TRIM_RST;
			crystal_drive_strength <= RCS_DRIVE_RST;
			feedback_count <= '0;
			feedback_fraction_add <= '0;
		end
		else
		begin
			primary_source_select <= next_primary_source_select;
			switchover_mode <= next_switchover_mode;
			prediv <= next_prediv;
			crystal_load_trim <= next_crystal_load_trim;
			crystal_drive_strength <= next_crystal_drive_strength;
			feedback_count <= next_feedback_count;
			feedback_fraction_add <= next_feedback_fraction_add;
		end
	end

	// Loss detection, source choice and glitch-free hand-over
	// Counts secondary rising edges, restarting on any primary edge
	// The first counted period after the last primary edge may be partial
	// References must run well below sys_clk for each level to be seen
	always_comb
	begin
		next_sec_periods = sec_periods;
		next_primary_lost = primary_lost;
		if (prim_edge)
		begin
			next_sec_periods = '0;
			next_primary_lost = 1'b0;
		end
		else if (sec_rise && !primary_lost)
		begin
			next_sec_periods = sec_periods + 1'b1;
			if (next_sec_periods == RCS_LOSS_PERIODS)
				next_primary_lost = 1'b1;
		end
		want_secondary = auto_mode ? primary_lost : pin_lvl;
		cur_lvl = using_secondary ? sec_lvl : prim_lvl;
		tgt_lvl = want_secondary ? sec_lvl : prim_lvl;
		next_using_secondary = using_secondary;
		// Swap only while both sides are low; a dead source is not waited on
		// A current source stuck high in manual mode holds off the swap
		if (want_secondary != using_secondary && !tgt_lvl
			&& (!cur_lvl || (auto_mode && primary_lost)))
			next_using_secondary = want_secondary;
		next_ref_out = next_using_secondary ? sec_lvl : prim_lvl;
	end

	// Selection state and the sampled reference copy
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sec_periods <= '0;
			primary_lost <= 1'b0;
			using_secondary <= 1'b0;
			ref_out <= 1'b0;
		end
		else
		begin
			sec_periods <= next_sec_periods;
			primary_lost <= next_primary_lost;
			using_secondary <= next_using_secondary;
			ref_out <= next_ref_out;
		end
	end

	// Derived PLL settings
	// The fourth PLL has no power-down code; its low codes are only flagged
	// Load capacitance counts eighths of a picofarad
	// Widest multiplier is twice the largest count plus the addend plus one
	always_comb
	begin
		for (int i = 0; i < RCS_NPLL; i++)
			next_pll_power_down[i] = (i != RCS_LAST_PLL) && (prediv[i] == RCS_DIV_OFF);
		next_pll3_div_invalid = prediv[RCS_LAST_PLL] < RCS_DIV3_MIN;
		next_load_cap_steps = RCS_CAP_BASE_STEPS + RCS_CAPW'(crystal_load_trim);
		if (feedback_fraction_add != '0)
			next_fb_multiplier = RCS_MW'({feedback_count, 1'b0})
				+ RCS_MW'(feedback_fraction_add) + RCS_MW'(1'b1);
		else
			next_fb_multiplier = RCS_MW'({feedback_count, 1'b0});
	end

	// Derived settings, one cycle behind the configuration registers
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pll_power_down <= '0;
			pll3_div_invalid <= 1'b0;
			load_cap_steps <= RCS_CAP_BASE_STEPS;
			fb_multiplier <= '0;
		end
		else
		begin
			pll_power_down <= next_pll_power_down;
			pll3_div_invalid <= next_pll3_div_invalid;
			load_cap_steps <= next_load_cap_steps;
			fb_multiplier <= next_fb_multiplier;
		end
	end

	// Read data, valid the cycle after the strobe, zero otherwise
	// Status packs the selection flags below the power-down bits
	// Divider offsets are matched in the default branch
	always_comb
	begin
		next_reg_rdata = '0;
		if (reg_rd)
		begin
			unique case (reg_addr)
				RCS_OFS_CTRL: next_reg_rdata = RCS_DW'({switchover_mode, primary_source_select});
				RCS_OFS_TRIM: next_reg_rdata = RCS_DW'(crystal_load_trim);
				RCS_OFS_DRIVE: next_reg_rdata = RCS_DW'(crystal_drive_strength);
				RCS_OFS_FEEDBACK: next_reg_rdata = {feedback_fraction_add, feedback_count};
				RCS_OFS_STATUS: next_reg_rdata = RCS_DW'({pll_power_down, pll3_div_invalid,
					primary_lost, using_secondary});
				RCS_OFS_MULT: next_reg_rdata = RCS_DW'(fb_multiplier);
				RCS_OFS_LOADCAP: next_reg_rdata = RCS_DW'(load_cap_steps);
				default:
				begin
					for (int i = 0; i < RCS_NPLL; i++)
					begin
						if (reg_addr == RCS_OFS_PREDIV0 + RCS_AW'(i))
							next_reg_rdata = RCS_DW'(prediv[i]);
					end
				end
			endcase
		end
	end

	// Read data register; zero between reads keeps the bus quiet
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= '0;
		else
			reg_rdata <= next_reg_rdata;
	end
endmodule
`default_nettype wire

// File: rtl/rcs_pkg.sv
// Constants shared by the reference clock switchover block
package rcs_pkg;
	localparam int RCS_AW = 4;
	localparam int RCS_DW = 16;
	localparam int RCS_NPLL = 4;
	localparam int RCS_DIVW = 7;
	localparam int RCS_TRIMW = 5;
	localparam int RCS_CAPW = 6;
	localparam int RCS_FBW = 12;
	localparam int RCS_FRW = 4;
	localparam int RCS_MW = 14;
	localparam int RCS_CNTW = 2;

	// Register offsets
	localparam logic [RCS_AW-1:0] RCS_OFS_CTRL = 4'h0;
	localparam logic [RCS_AW-1:0] RCS_OFS_PREDIV0 = 4'h1;
	localparam logic [RCS_AW-1:0] RCS_OFS_TRIM = 4'h5;
	localparam logic [RCS_AW-1:0] RCS_OFS_DRIVE = 4'h6;
	localparam logic [RCS_AW-1:0] RCS_OFS_FEEDBACK = 4'h7;
	localparam logic [RCS_AW-1:0] RCS_OFS_STATUS = 4'h8;
	localparam logic [RCS_AW-1:0] RCS_OFS_MULT = 4'h9;
	localparam logic [RCS_AW-1:0] RCS_OFS_LOADCAP = 4'ha;

	// Control and feedback field positions
	localparam int RCS_CTRL_PRIM_BIT = 0;
	localparam int RCS_CTRL_MODE_LO = 1;
	localparam int RCS_CTRL_MODE_HI = 2;
	localparam int RCS_FB_ADD_LO = 12;

	// Reset values
	localparam logic [RCS_DIVW-1:0] RCS_PREDIV_RST = 7'h01;
	localparam logic [RCS_DIVW-1:0] RCS_PREDIV3_RST = 7'h03;
	localparam logic [RCS_TRIMW-1:0] RCS_TRIM_RST = 5'h00;
	localparam logic [1:0] RCS_DRIVE_RST = 2'h3;

	// Pre-divider codes
	localparam logic [RCS_DIVW-1:0] RCS_DIV_OFF = 7'h00;
	localparam logic [RCS_DIVW-1:0] RCS_DIV3_MIN = 7'h03;
	localparam int RCS_LAST_PLL = 3;

	// Load capacitance in eighths of a picofarad: 3.5 pF base, 0.125 pF step
	localparam real RCS_CAP_BASE_PF = 3.5;
	localparam real RCS_CAP_STEP_PF = 0.125;
	localparam logic [RCS_CAPW-1:0] RCS_CAP_BASE_STEPS = 6'(int'(RCS_CAP_BASE_PF / RCS_CAP_STEP_PF));

	// Missing-primary threshold in secondary periods
	localparam logic [RCS_CNTW-1:0] RCS_LOSS_PERIODS = 2'h2;
endpackage

// File: test/rcs_ref_switch_props.sv
// Port checker for the reference switch
`timescale 1ns/1ps
`default_nettype none
module rcs_ref_switch_chk
	import rcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic input_clock_select_pin,
	input wire logic [RCS_AW-1:0] reg_addr,
	input wire logic [RCS_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [RCS_DW-1:0] reg_rdata,
	input wire logic ref_out,
	input wire logic using_secondary,
	input wire logic primary_lost,
	input wire logic [RCS_NPLL-1:0] pll_power_down,
	input wire logic pll3_div_invalid,
	input wire logic [RCS_CAPW-1:0] load_cap_steps,
	input wire logic [RCS_MW-1:0] fb_multiplier
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic auto_md;
	logic next_auto_md;
	// Expected multiplier from a feedback word
	function automatic logic [RCS_MW-1:0] mult(input logic [RCS_DW-1:0] w);
		mult = RCS_MW'({w[11:0], 1'b0})
			+ ((w[15:12] != 4'h0) ? RCS_MW'(w[15:12]) + RCS_MW'(1'b1) : RCS_MW'(1'b0));
	endfunction
	// Mirror of the automatic mode bit
	always_comb
	begin
		next_auto_md = auto_md;
		if (reg_wr && reg_addr == RCS_OFS_CTRL)
			next_auto_md = reg_wdata[RCS_CTRL_MODE_HI];
	end
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			auto_md <= 1'b0;
		else
			auto_md <= next_auto_md;
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("read data stray");
	AST_CLEAN: assert property ($changed(using_secondary) |-> !ref_out)
		else $error("switch with output high");
	AST_PD3: assert property (!pll_power_down[3]) else $error("fourth PLL powered down");
	AST_PD0: assert property (reg_wr && reg_addr == RCS_OFS_PREDIV0 |-> ##2
		pll_power_down[0] == ($past(reg_wdata[6:0], 2) == 7'h00)) else $error("power down wrong");
	AST_DIV3: assert property (reg_wr && reg_addr == 4'h4 |-> ##2
		pll3_div_invalid == ($past(reg_wdata[6:0], 2) < 7'h03)) else $error("divider flag wrong");
	AST_CAP: assert property (reg_wr && reg_addr == RCS_OFS_TRIM |-> ##2
		load_cap_steps == RCS_CAP_BASE_STEPS + 6'($past(reg_wdata[4:0], 2)))
		else $error("load cap wrong");
	AST_MULT: assert property (reg_wr && reg_addr == RCS_OFS_FEEDBACK |-> ##2
		fb_multiplier == mult($past(reg_wdata, 2))) else $error("multiplier wrong");
	AST_LOSS: assert property (auto_md && $rose(primary_lost) |-> ##[0:1000] using_secondary)
		else $error("no switch on loss");
	AST_REVERT: assert property (auto_md && $fell(primary_lost) |-> ##[0:1000] !using_secondary)
		else $error("no revert");
	AST_MANUAL: assert property (!auto_md && $rose(using_secondary) |->
		$past(input_clock_select_pin, 3)) else $error("manual switch without pin");
	cover property (auto_md && $rose(using_secondary));
	cover property (!auto_md && $rose(using_secondary));
	cover property ($rose(pll3_div_invalid));
endmodule
bind rcs_ref_switch rcs_ref_switch_chk i_chk (.sys_clk, .arst_n, .input_clock_select_pin,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_out, .using_secondary,
	.primary_lost, .pll_power_down, .pll3_div_invalid, .load_cap_steps, .fb_multiplier);
`default_nettype wire

// File: test/rcs_ref_src.sv
// External reference sources, stoppable
`timescale 1ns/1ps
`default_nettype none
module rcs_ref_src (
	input wire logic run_a,
	input wire logic run_b,
	output logic crystal_or_ref_input,
	output logic second_ref_input
);
	// Oscillator-free external references only, held low when stopped
	initial crystal_or_ref_input = 1'b0;
	initial second_ref_input = 1'b0;
	always #410 crystal_or_ref_input = run_a ? ~crystal_or_ref_input : 1'b0;
	// Secondary slower than primary
	always #615 second_ref_input = run_b ? ~second_ref_input : 1'b0;
endmodule
`default_nettype wire

// File: test/rcs_ref_switch_tb.sv
// Self-checking bench for the reference switch
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module rcs_ref_switch_tb
	import rcs_pkg::*;
;
	logic sys_clk = 0;
	logic arst_n = 0;
	logic sel = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic run_a = 1;
	logic run_b = 1;
	logic rd_seen = 0;
	logic s;
	logic [3:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0;
	logic [15:0] reg_rdata;
	logic [15:0] v;
	logic [15:0] exp_rd;
	logic [15:0] a;
	logic [15:0] q[$];
	wire logic ra;
	wire logic rb;
	wire logic ref_out;
	wire logic usec;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	rcs_ref_src i_src (.run_a(run_a), .run_b(run_b), .crystal_or_ref_input(ra),
		.second_ref_input(rb));
	rcs_ref_switch i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .crystal_or_ref_input(ra),
		.second_ref_input(rb), .input_clock_select_pin(sel), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ref_out(ref_out), .using_secondary(usec), .primary_lost(), .pll_power_down(),
		.pll3_div_invalid(), .load_cap_steps(), .crystal_drive_strength(), .fb_multiplier());
	always #25 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	// Read data checked against the oldest note
	always @(posedge sys_clk) rd_seen <= reg_rd;
	always @(negedge sys_clk)
		if (rd_seen)
		begin
			exp_rd = q.pop_front();
			`CHK(reg_rdata, exp_rd)
		end
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Wait bounded for the selection flag
	task automatic wsec(input logic e);
		int n;
		n = 0;
		while (usec !== e && n < 400)
		begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(usec, e)
	endtask
	task automatic hi_seen(output logic h);
		h = 1'b0;
		repeat (150) @(negedge sys_clk) h = h | (ref_out === 1'b1);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		v = $urandom(57);
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(RCS_OFS_STATUS, 16'h0000);
		rd(RCS_OFS_LOADCAP, 16'h001c);
		rd(RCS_OFS_DRIVE, 16'h0003);
		rd(4'hf, 16'h0000);
		$display("reset test done");
		// Trim and multiplier, boundaries then random
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 16'h001f : 16'($urandom % 32);
			wr(RCS_OFS_TRIM, v);
			rd(RCS_OFS_LOADCAP, v + 16'h001c);
			a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h000f : 16'($urandom % 16);
			v = (i == 1) ? 16'h0fff : 16'($urandom % 4096);
			wr(RCS_OFS_FEEDBACK, (a << 12) | v);
			rd(RCS_OFS_MULT, 2 * v + ((a != 0) ? a + 1 : 0));
		end
		$display("trim and multiplier test done");
		// Divider zero codes with code 2 on the fourth PLL, then legal random codes
		for (int i = 0; i < 4; i++)
			wr(4'(RCS_OFS_PREDIV0 + i), (i == 3) ? 16'h0002 : 16'h0000);
		rd(RCS_OFS_STATUS, 16'h003c);
		for (int i = 0; i < 4; i++)
			wr(4'(RCS_OFS_PREDIV0 + i), (i == 3) ? 16'($urandom % 125 + 3) : 16'($urandom % 127 + 1));
		rd(RCS_OFS_STATUS, 16'h0000);
		$display("divider test done");
		// Manual selection by the pin
		wr(RCS_OFS_CTRL, 16'h0002);
		sel <= 1'b1;
		wsec(1'b1);
		rd(RCS_OFS_STATUS, 16'h0001);
		sel <= 1'b0;
		wsec(1'b0);
		// Second input as primary, first stopped
		run_a <= 1'b0;
		wr(RCS_OFS_CTRL, 16'h0001);
		hi_seen(s);
		`CHK(s, 1'b1)
		sel <= 1'b1;
		wsec(1'b1);
		hi_seen(s);
		`CHK(s, 1'b0)
		$display("manual test done");
		// Automatic: pin ignored, loss and revert
		run_a <= 1'b1;
		wr(RCS_OFS_CTRL, 16'h0004);
		wsec(1'b0);
		run_a <= 1'b0;
		wsec(1'b1);
		rd(RCS_OFS_STATUS, 16'h0003);
		run_a <= 1'b1;
		wsec(1'b0);
		rd(RCS_OFS_STATUS, 16'h0000);
		$display("automatic test done");
		end_of_test();
	end
endmodule
`default_nettype wire
